// >>> src/deep_sleep_state_retention_map.svh
/*
 * constants for the deep-sleep retention control block: timing counts and reset values.
 * assumes inclusion by bare name; definitions only.
 */
`ifndef DEEP_SLEEP_STATE_RETENTION_MAP_SVH
`define DEEP_SLEEP_STATE_RETENTION_MAP_SVH

// ****************************************************************
// timing
// ****************************************************************
`define SLOW_OSC_SYNC_CYCLES   3'h5
`define SLOW_OSC_CNT_ZERO      3'h0
`define SLOW_OSC_CNT_ONE       3'h1

// ****************************************************************
// pin select codes and reset values
// ****************************************************************
`define PIN_SEL_GPIO           4'h0
`define PIN_SEL_LIN            4'h1
`define PIN_SEL_CANFD          4'h2
`define WDT_FLAGS_RST          2'h0
`define STATUS_WORD_RST        16'h0000

`endif

// >>> src/deep_sleep_state_retention_pkg.sv
/*
 * types for the deep-sleep retention control block.
 * assumes the map header supplies all numeric constants.
 */
package deep_sleep_state_retention_pkg;

    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_DEEP_SLEEP,
        PWR_WAKE
    } pwr_state_t;

    // volatile status values that are lost across deep sleep
    typedef struct packed {
        logic [15:0] low_voltage_detect_state;
        logic [15:0] low_voltage_detect_state_two;
        logic [15:0] clock_calibration_count_one;
        logic [15:0] clock_calibration_count_two;
        logic [15:0] freq_loop_state;
        logic [15:0] phase_loop_state;
        logic [15:0] converter_channel_result;
    } volatile_status_t;

    typedef struct packed {
        logic [1:0] watchdog_irq_flags;
        logic [1:0] watchdog_irq_masked_flags;
    } watchdog_irq_t;

endpackage

// >>> src/deep_sleep_state_retention_control.sv
/*
 * deep-sleep and retention control: bandgap low-power select gating, sram retention,
 * watchdog reset handling, lin and can fd pin hold on wake and volatile status loss.
 * assumes all inputs synchronous to CLK_IN; software drives the control ports directly.
 */
// Notes on behaviour
// - watchdog reset always drops sram retention, even after orderly shutdown.
// - bandgap low-power select sets only while slow oscillator 0 is enabled.
// - peripheral-routed pins other than lin or can fd lose output level on wake.
// - listed status values are not kept across deep sleep.
`timescale 1ns/10ps
`include "deep_sleep_state_retention_map.svh"

module deep_sleep_state_retention_control #(
    parameter int SEL_W = 4
) (
    input  wire logic                                     CLK_IN,
    input  wire logic                                     RST_B_IN,
    input  wire logic                                     WATCHDOG_RESET_IN,
    input  wire logic                                     SRAM_RETAIN_REQ_IN,
    input  wire logic                                     SLOW_OSC0_ON_IN,
    input  wire logic                                     SLOW_OSC0_TICK_IN,
    input  wire logic                                     BANDGAP_LOWPOWER_WR_IN,
    input  wire logic                                     BANDGAP_LOWPOWER_VAL_IN,
    input  wire logic                                     DEEP_SLEEP_REQ_IN,
    input  wire logic                                     WAKE_IN,
    input  wire logic [SEL_W-1:0]                         PIN_FUNCTION_SELECT_IN,
    input  wire logic                                     GPIO_OUT_IN,
    input  wire logic                                     PERIPH_OUT_IN,
    input  wire deep_sleep_state_retention_pkg::volatile_status_t STATUS_IN,
    input  wire logic                                     STATUS_UPDATE_IN,
    input  wire logic [1:0]                               WATCHDOG_IRQ_SET_IN,
    input  wire logic [1:0]                               WATCHDOG_IRQ_CLR_IN,
    input  wire logic [1:0]                               WATCHDOG_IRQ_MASK_IN,
    output logic                                          SRAM_RETAINED_OUT,
    output logic                                          BANDGAP_LOWPOWER_SELECT_OUT,
    output logic                                          BANDGAP_SYNC_BUSY_OUT,
    output logic                                          DEEP_SLEEP_STATE_OUT,
    output logic                                          PIN_LEVEL_OUT,
    output deep_sleep_state_retention_pkg::volatile_status_t      STATUS_OUT,
    output deep_sleep_state_retention_pkg::watchdog_irq_t         WATCHDOG_IRQ_OUT
);

    // ****************************************************************
    // decode
    // ****************************************************************
    deep_sleep_state_retention_pkg::pwr_state_t state_q;
    deep_sleep_state_retention_pkg::pwr_state_t state_d;
    logic       retained_q;
    logic       lp_sel_q;
    logic [2:0] sync_cnt_q;
    logic [1:0] irq_q;
    logic       pin_q;

    wire in_sleep    = (state_q == deep_sleep_state_retention_pkg::PWR_DEEP_SLEEP);
    wire waking      = in_sleep && WAKE_IN;
    wire lp_set_ok   = BANDGAP_LOWPOWER_WR_IN && BANDGAP_LOWPOWER_VAL_IN && SLOW_OSC0_ON_IN;
    wire lp_clear    = BANDGAP_LOWPOWER_WR_IN && !BANDGAP_LOWPOWER_VAL_IN;
    wire lp_sel_d    = lp_set_ok ? 1'b1 : (lp_clear ? 1'b0 : lp_sel_q);
    // only lin and can fd keep peripheral level
    wire pin_is_gpio = (PIN_FUNCTION_SELECT_IN == SEL_W'(`PIN_SEL_GPIO));
    wire pin_kept    = (PIN_FUNCTION_SELECT_IN == SEL_W'(`PIN_SEL_LIN))
                    || (PIN_FUNCTION_SELECT_IN == SEL_W'(`PIN_SEL_CANFD));
    wire pin_src     = pin_is_gpio ? GPIO_OUT_IN : PERIPH_OUT_IN;
    // set wins over clear
    wire [1:0] irq_d = (irq_q & ~WATCHDOG_IRQ_CLR_IN) | WATCHDOG_IRQ_SET_IN;

    always_comb begin
        state_d = state_q;
        case (state_q)
            deep_sleep_state_retention_pkg::PWR_ACTIVE: begin
                if (DEEP_SLEEP_REQ_IN) begin
                    state_d = deep_sleep_state_retention_pkg::PWR_DEEP_SLEEP;
                end
            end
            deep_sleep_state_retention_pkg::PWR_DEEP_SLEEP: begin
                if (WAKE_IN) begin
                    state_d = deep_sleep_state_retention_pkg::PWR_WAKE;
                end
            end
            deep_sleep_state_retention_pkg::PWR_WAKE: begin
                state_d = deep_sleep_state_retention_pkg::PWR_ACTIVE;
            end
            default: begin
                state_d = deep_sleep_state_retention_pkg::PWR_ACTIVE;
            end
        endcase
    end

    // ****************************************************************
    // power state and watchdog reset
    // ****************************************************************
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            state_q <= deep_sleep_state_retention_pkg::PWR_ACTIVE;
        end else if (WATCHDOG_RESET_IN) begin
            state_q <= deep_sleep_state_retention_pkg::PWR_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    // watchdog reset outranks any warning-time orderly shutdown
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            retained_q <= 1'b0;
        end else if (WATCHDOG_RESET_IN) begin
            retained_q <= 1'b0;
        end else begin
            retained_q <= SRAM_RETAIN_REQ_IN;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            irq_q <= `WDT_FLAGS_RST;
        end else if (WATCHDOG_RESET_IN) begin
            irq_q <= `WDT_FLAGS_RST;
        end else if (waking) begin
            // old flags not kept; a set in the wake cycle still wins
            irq_q <= `WDT_FLAGS_RST | WATCHDOG_IRQ_SET_IN;
        end else begin
            irq_q <= irq_d;
        end
    end

    // ****************************************************************
    // bandgap low-power select
    // ****************************************************************
    // busy counts slow-oscillator ticks after a clear; software must keep it running meanwhile
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            lp_sel_q   <= 1'b0;
            sync_cnt_q <= `SLOW_OSC_CNT_ZERO;
        end else begin
            lp_sel_q <= lp_sel_d;
            if (lp_sel_q && !lp_sel_d) begin
                sync_cnt_q <= `SLOW_OSC_SYNC_CYCLES;
            end else if (SLOW_OSC0_TICK_IN && (sync_cnt_q != `SLOW_OSC_CNT_ZERO)) begin
                sync_cnt_q <= sync_cnt_q - `SLOW_OSC_CNT_ONE;
            end
        end
    end

    // ****************************************************************
    // pin level and volatile status
    // ****************************************************************
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            pin_q <= 1'b0;
        end else if (waking && !pin_is_gpio && !pin_kept) begin
            pin_q <= 1'b0;
        end else if (!in_sleep) begin
            pin_q <= pin_src;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            STATUS_OUT <= '0;
        end else if (waking) begin
            STATUS_OUT <= '0;
        end else if (STATUS_UPDATE_IN && !in_sleep) begin
            STATUS_OUT <= STATUS_IN;
        end
    end

    // ****************************************************************
    // registered outputs
    // ****************************************************************
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            SRAM_RETAINED_OUT           <= 1'b0;
            BANDGAP_LOWPOWER_SELECT_OUT <= 1'b0;
            BANDGAP_SYNC_BUSY_OUT       <= 1'b0;
            DEEP_SLEEP_STATE_OUT        <= 1'b0;
            PIN_LEVEL_OUT               <= 1'b0;
            WATCHDOG_IRQ_OUT            <= '0;
        end else begin
            SRAM_RETAINED_OUT           <= retained_q;
            BANDGAP_LOWPOWER_SELECT_OUT <= lp_sel_q;
            BANDGAP_SYNC_BUSY_OUT       <= (sync_cnt_q != `SLOW_OSC_CNT_ZERO);
            DEEP_SLEEP_STATE_OUT        <= in_sleep;
            PIN_LEVEL_OUT               <= pin_q;
            WATCHDOG_IRQ_OUT            <= {irq_q, irq_q & WATCHDOG_IRQ_MASK_IN};
        end
    end

endmodule

// >>> bench/deep_sleep_state_retention_props.sv
/*
 * checker for the deep-sleep retention control block.
 * assumes binding to the block's top ports; watches the block's outputs and the inputs that gate them.
 */
`timescale 1ns/10ps
module deep_sleep_state_retention_props #(
    parameter int SEL_W = 4
) (
    input wire logic                                     CLK_IN,
    input wire logic                                     RST_B_IN,
    input wire logic                                     WATCHDOG_RESET_IN,
    input wire logic                                     SLOW_OSC0_ON_IN,
    input wire logic                                     SLOW_OSC0_TICK_IN,
    input wire logic                                     BANDGAP_LOWPOWER_WR_IN,
    input wire logic                                     BANDGAP_LOWPOWER_VAL_IN,
    input wire logic                                     DEEP_SLEEP_REQ_IN,
    input wire logic                                     STATUS_UPDATE_IN,
    input wire logic                                     SRAM_RETAINED_OUT,
    input wire logic                                     BANDGAP_LOWPOWER_SELECT_OUT,
    input wire logic                                     BANDGAP_SYNC_BUSY_OUT,
    input wire logic                                     DEEP_SLEEP_STATE_OUT,
    input wire logic                                     PIN_LEVEL_OUT,
    input wire logic [SEL_W-1:0]                         PIN_FUNCTION_SELECT_IN,
    input wire deep_sleep_state_retention_pkg::volatile_status_t STATUS_OUT,
    input wire deep_sleep_state_retention_pkg::watchdog_irq_t    WATCHDOG_IRQ_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    wdt_clears_a: assert property (WATCHDOG_RESET_IN |-> ##2 (!SRAM_RETAINED_OUT && WATCHDOG_IRQ_OUT == 4'h0))
        else $error("retention or irq flags survive watchdog reset");
    lp_gate_a: assert property ($rose(BANDGAP_LOWPOWER_SELECT_OUT) |-> $past(SLOW_OSC0_ON_IN, 2)
        && $past(BANDGAP_LOWPOWER_WR_IN, 2) && $past(BANDGAP_LOWPOWER_VAL_IN, 2)) else $error("low-power set ungated");
    busy_start_a: assert property ($rose(BANDGAP_SYNC_BUSY_OUT) |-> $past(BANDGAP_LOWPOWER_WR_IN, 2)
        && !$past(BANDGAP_LOWPOWER_VAL_IN, 2)) else $error("sync window without clear");
    busy_end_a: assert property ($fell(BANDGAP_SYNC_BUSY_OUT) |-> $past(SLOW_OSC0_TICK_IN, 2))
        else $error("sync window ended without slow tick");
    sleep_entry_a: assert property ($rose(DEEP_SLEEP_STATE_OUT) |-> $past(DEEP_SLEEP_REQ_IN, 2))
        else $error("sleep entered without request");
    pin_frozen_a: assert property (DEEP_SLEEP_STATE_OUT && $past(DEEP_SLEEP_STATE_OUT) |-> $stable(PIN_LEVEL_OUT))
        else $error("pin moved during sleep");
    // a watchdog reset also ends sleep but is not a wake, so it is left out here
    pin_lost_a: assert property ($fell(DEEP_SLEEP_STATE_OUT) && !$past(WATCHDOG_RESET_IN, 2)
        && $past(PIN_FUNCTION_SELECT_IN, 2) > 4'h2 |-> !PIN_LEVEL_OUT)
        else $error("peripheral pin level kept over wake");
    status_lost_a: assert property ($fell(DEEP_SLEEP_STATE_OUT) && !$past(WATCHDOG_RESET_IN, 2)
        && !$past(STATUS_UPDATE_IN) |-> STATUS_OUT == 112'h0)
        else $error("status kept over wake");
endmodule

bind deep_sleep_state_retention_control deep_sleep_state_retention_props #(.SEL_W(SEL_W)) chk (.*);

// >>> bench/tb_top.sv
/*
 * self-checking bench for the deep-sleep retention control block.
 * assumes the block and its checker are compiled first; drives inputs at the falling edge.
 */
`timescale 1ns/10ps
`include "deep_sleep_state_retention_map.svh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s expected %0h seen %0h", n, e, a); end end
module tb_top;
    logic        clk = 1'b0, rst_b = 1'b0, wdt = 1'b0, ret_req = 1'b0, osc_on = 1'b0, tick = 1'b0;
    logic        bg_wr = 1'b0, bg_val = 1'b0, sleep_req = 1'b0, wake = 1'b0, gpio = 1'b0, periph = 1'b0;
    logic        st_upd = 1'b0, ret_out, bg_sel, bg_busy, sleep_out, pin_out, e;
    logic [3:0]  sel = 4'h0;
    logic [1:0]  irq_set = 2'h0, irq_clr = 2'h0, irq_mask = 2'h0;
    logic [15:0] seed = 16'h67C0, r;
    int          n_mismatch = 0, tests_run = 0, i;
    deep_sleep_state_retention_pkg::volatile_status_t st_in = '0, st_out;
    deep_sleep_state_retention_pkg::watchdog_irq_t    irq_out;

    deep_sleep_state_retention_control uut (.CLK_IN(clk), .RST_B_IN(rst_b), .WATCHDOG_RESET_IN(wdt),
        .SRAM_RETAIN_REQ_IN(ret_req), .SLOW_OSC0_ON_IN(osc_on), .SLOW_OSC0_TICK_IN(tick),
        .BANDGAP_LOWPOWER_WR_IN(bg_wr), .BANDGAP_LOWPOWER_VAL_IN(bg_val), .DEEP_SLEEP_REQ_IN(sleep_req),
        .WAKE_IN(wake), .PIN_FUNCTION_SELECT_IN(sel), .GPIO_OUT_IN(gpio), .PERIPH_OUT_IN(periph),
        .STATUS_IN(st_in), .STATUS_UPDATE_IN(st_upd), .WATCHDOG_IRQ_SET_IN(irq_set),
        .WATCHDOG_IRQ_CLR_IN(irq_clr), .WATCHDOG_IRQ_MASK_IN(irq_mask), .SRAM_RETAINED_OUT(ret_out),
        .BANDGAP_LOWPOWER_SELECT_OUT(bg_sel), .BANDGAP_SYNC_BUSY_OUT(bg_busy),
        .DEEP_SLEEP_STATE_OUT(sleep_out), .PIN_LEVEL_OUT(pin_out), .STATUS_OUT(st_out),
        .WATCHDOG_IRQ_OUT(irq_out));

    initial forever #50 clk = ~clk;

    function logic [15:0] xs();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction

    // level a pin shows straight after wake: only gpio, lin and can fd hold it
    function logic exp_pin(input logic [3:0] s, input logic g, input logic p);
        if (s == `PIN_SEL_GPIO) return g;
        return (s == `PIN_SEL_LIN || s == `PIN_SEL_CANFD) ? p : 1'b0;
    endfunction

    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task results();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // generous: the sequence needs well under a thousand cycles
    initial begin
        #2000000;
        n_mismatch++;
        results();
    end

    initial begin
        cyc(6);
        rst_b = 1'b1;
        cyc(1);
        `CHK("retained_rst", 1'b0, ret_out)
        bg_wr = 1'b1; bg_val = 1'b1; cyc(1); bg_wr = 1'b0; cyc(3);
        `CHK("lp_osc_off", 1'b0, bg_sel)
        osc_on = 1'b1; bg_wr = 1'b1; cyc(1); bg_wr = 1'b0; cyc(3);
        `CHK("lp_osc_on", 1'b1, bg_sel)
        bg_val = 1'b0; bg_wr = 1'b1; cyc(1); bg_wr = 1'b0; cyc(3);
        for (i = 0; i < 5; i++) begin
            `CHK("sync_busy", 1'b1, bg_busy)
            tick = 1'b1; cyc(1); tick = 1'b0; cyc(2);
        end
        cyc(2);
        `CHK("sync_done", 1'b0, bg_busy)
        for (i = 0; i < 12; i++) begin
            r = xs();
            sel = (i < 4) ? i[3:0] : r[3:0];
            gpio = r[4]; periph = r[5];
            st_in = {r, ~r, r ^ 16'h5A5A, r + 16'h1, ~r, r, r ^ 16'hA5A5};
            st_upd = 1'b1; cyc(1); st_upd = 1'b0; cyc(2);
            `CHK("status_load", st_in, st_out)
            e = (sel == `PIN_SEL_GPIO) ? gpio : periph;
            `CHK("pin_before", e, pin_out)
            sleep_req = 1'b1; cyc(1); sleep_req = 1'b0; cyc(2);
            `CHK("asleep", 1'b1, sleep_out)
            gpio = ~gpio; periph = ~periph; st_in = ~st_in; st_upd = 1'b1; cyc(2); st_upd = 1'b0;
            `CHK("pin_frozen", e, pin_out)
            `CHK("status_frozen", ~st_in, st_out)
            // live levels stay inverted so a pass-through cannot pose as a held level
            wake = 1'b1; cyc(1); wake = 1'b0; cyc(1);
            `CHK("awake", 1'b0, sleep_out)
            `CHK("pin_wake", exp_pin(sel, ~gpio, ~periph), pin_out)
            `CHK("status_lost", 112'h0, st_out)
            cyc(2);
        end
        irq_mask = 2'h3; irq_set = 2'h3; ret_req = 1'b1; cyc(1); irq_set = 2'h0; cyc(3);
        `CHK("retained", 1'b1, ret_out)
        `CHK("irq_set", 4'hF, irq_out)
        irq_clr = 2'h1; cyc(1); irq_clr = 2'h0; cyc(3);
        `CHK("irq_clr", 4'hA, irq_out)
        irq_set = 2'h3; irq_clr = 2'h3; cyc(1); irq_set = 2'h0; irq_clr = 2'h0; cyc(3);
        `CHK("irq_set_wins", 4'hF, irq_out)
        irq_mask = 2'h1; cyc(3);
        `CHK("irq_mask", 4'hD, irq_out)
        sleep_req = 1'b1; cyc(1); sleep_req = 1'b0; cyc(2);
        wake = 1'b1; cyc(1); wake = 1'b0; cyc(1);
        `CHK("irq_wake", 4'h0, irq_out)
        irq_set = 2'h3; sleep_req = 1'b1; cyc(1); irq_set = 2'h0; sleep_req = 1'b0; cyc(2);
        `CHK("asleep_wdt", 1'b1, sleep_out)
        wdt = 1'b1; cyc(2);
        `CHK("retained_wdt", 1'b0, ret_out)
        `CHK("irq_wdt", 4'h0, irq_out)
        `CHK("sleep_wdt", 1'b0, sleep_out)
        wdt = 1'b0; cyc(2);
        `CHK("retained_back", 1'b1, ret_out)
        rst_b = 1'b0; cyc(1);
        `CHK("retained_rst2", 1'b0, ret_out)
        rst_b = 1'b1; cyc(2);
        results();
    end
endmodule
